// >>> design/timer_two_defs.svh
/*
 * Register offsets, bit positions, reset values and interrupt status bit indices of the
 * timer two control block. Assumes inclusion by bare name from design files.
 */
`ifndef TIMER_TWO_DEFS_SVH
`define TIMER_TWO_DEFS_SVH

`define T2_CTRL_ADDR 8'hC8
`define T2_IRQ_STATUS_ADDR 8'hC9
`define T2_IRQ_CLEAR_ADDR 8'hCA
`define T2_IRQ_ENABLE_ADDR 8'hCB
`define T2_COUNT_LO_ADDR 8'hCC
`define T2_COUNT_HI_ADDR 8'hCD
`define T2_RELOAD_LO_ADDR 8'hCE
`define T2_RELOAD_HI_ADDR 8'hCF
`define T2_MODE_ADDR 8'hD0

`define T2_BIT_OVF 7
`define T2_BIT_EXT 6
`define T2_BIT_RXSEL 5
`define T2_BIT_TXSEL 4
`define T2_BIT_EXTEN 3
`define T2_BIT_RUN 2
`define T2_BIT_CT 1
`define T2_BIT_CPRL 0

`define T2_CTRL_RESET 8'h00
`define T2_WORD_RESET 16'h0000

`define T2_IRQ_OVF 0
`define T2_IRQ_EXT 1
`define T2_IRQ_BAUD 2

`endif

// >>> design/timer_two_pkg.sv
/*
 * Types shared by the timer two control block and its register memory.
 * Assumes the defs header carries every numeric constant.
 */
package timer_two_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [15:0] word_t;
	typedef enum logic [1:0] {
		ACC_NONE,
		ACC_WRITE,
		ACC_READ
	} access_t;
endpackage : timer_two_pkg

// >>> design/timer_two_word_if.sv
/*
 * Carrier between the control block and the count/reload store.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/10ps
interface timer_two_word_if;
	timer_two_pkg::word_t countWr;
	logic countWe;
	timer_two_pkg::word_t countRd;
	timer_two_pkg::word_t reloadWr;
	logic reloadWe;
	timer_two_pkg::word_t reloadRd;
	modport ctrl (output countWr, output countWe, input countRd, output reloadWr, output reloadWe, input reloadRd);
	modport store (input countWr, input countWe, output countRd, input reloadWr, input reloadWe, output reloadRd);
endinterface : timer_two_word_if

// >>> design/timer_two_store.sv
/*
 * Count and reload/capture words of timer two, read data from registers.
 * Assumes the control block writes at most one word of each per cycle.
 */
`timescale 1ns/10ps
`include "timer_two_defs.svh"
module timer_two_store (
	input wire logic core_clk,
	input wire logic srst,
	timer_two_word_if.store words
);
	timer_two_pkg::word_t count_q;
	timer_two_pkg::word_t reload_q;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			count_q <= `T2_WORD_RESET;
		end else if (words.countWe) begin
			count_q <= words.countWr;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			reload_q <= `T2_WORD_RESET;
		end else if (words.reloadWe) begin
			reload_q <= words.reloadWr;
		end
	end

	assign words.countRd = count_q;
	assign words.reloadRd = reload_q;
endmodule : timer_two_store

// >>> design/timer_two_ctrl.sv
/*
 * Control register, flags, counting and interrupt of timer two.
 * Assumes pins synchronous to core_clk and a one-cycle strobe register port.
 */
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
`include "timer_two_defs.svh"
module timer_two_ctrl (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] bitMask,
	input wire logic externalTriggerPin,
	input wire logic countPin,
	input wire logic timerOneOverflow,
	input wire logic updownCountEnable,
	input wire logic timerIrqEnable,
	output logic [7:0] regRdData,
	output logic timerIrq,
	output logic rxBaudClock,
	output logic txBaudClock,
	output logic irqLine
);
	timer_two_word_if words ();

	timer_two_store store_inst (
		.core_clk(core_clk),
		.srst(srst),
		.words(words)
	);

	////////////////////////////////////////////////////////////////////////////
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
		hit = addr == target;
	endfunction : hit

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] val, input logic [7:0] mask);
		merge = (old & ~mask) | (val & mask);
	endfunction : merge

	////////////////////////////////////////////////////////////////////////////
	logic [7:0] ctrl_q;
	logic [2:0] irqStatus_q;
	logic [2:0] irqEnable_q;
	logic trigPrev_q;
	logic countPrev_q;
	logic ovfPulse;
	logic trigFall;
	logic countTick;
	logic baudMode;
	logic writeCtrl;
	logic [7:0] ctrlWr;

	assign baudMode = ctrl_q[`T2_BIT_RXSEL] | ctrl_q[`T2_BIT_TXSEL];
	assign trigFall = trigPrev_q & ~externalTriggerPin & ctrl_q[`T2_BIT_EXTEN];
	assign countTick = ctrl_q[`T2_BIT_RUN] &
		(ctrl_q[`T2_BIT_CT] ? (countPrev_q & ~countPin) : 1'b1);
	assign ovfPulse = countTick & (words.countRd == 16'hFFFF);
	assign writeCtrl = regWrite & hit(regAddr, `T2_CTRL_ADDR);
	// bit mask lets a single-bit instruction touch one bit only
	assign ctrlWr = merge(ctrl_q, regWrData, bitMask);

	always_ff @(posedge core_clk) begin
		if (srst) begin
			trigPrev_q <= 1'b1;
			countPrev_q <= 1'b1;
		end else begin
			trigPrev_q <= externalTriggerPin;
			countPrev_q <= countPin;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// flags: hardware set wins over a same-cycle software clear
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ctrl_q <= `T2_CTRL_RESET;
		end else begin
			if (writeCtrl) begin
				ctrl_q <= ctrlWr;
			end
			if (ovfPulse & ~baudMode) begin
				ctrl_q[`T2_BIT_OVF] <= 1'b1;
			end
			if (trigFall) begin
				ctrl_q[`T2_BIT_EXT] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// counting, capture and reload
	always_comb begin
		words.countWe = 1'b0;
		words.countWr = words.countRd;
		words.reloadWe = 1'b0;
		words.reloadWr = words.reloadRd;
		if (regWrite & hit(regAddr, `T2_COUNT_LO_ADDR)) begin
			words.countWe = 1'b1;
			words.countWr = {words.countRd[15:8], regWrData};
		end else if (regWrite & hit(regAddr, `T2_COUNT_HI_ADDR)) begin
			words.countWe = 1'b1;
			words.countWr = {regWrData, words.countRd[7:0]};
		end else if (ovfPulse & (baudMode | ~ctrl_q[`T2_BIT_CPRL])) begin
			words.countWe = 1'b1;
			words.countWr = words.reloadRd;
		end else if (trigFall & ~baudMode & ~ctrl_q[`T2_BIT_CPRL]) begin
			words.countWe = 1'b1;
			words.countWr = words.reloadRd;
		end else if (countTick) begin
			words.countWe = 1'b1;
			words.countWr = words.countRd + 16'h0001;
		end
		if (regWrite & hit(regAddr, `T2_RELOAD_LO_ADDR)) begin
			words.reloadWe = 1'b1;
			words.reloadWr = {words.reloadRd[15:8], regWrData};
		end else if (regWrite & hit(regAddr, `T2_RELOAD_HI_ADDR)) begin
			words.reloadWe = 1'b1;
			words.reloadWr = {regWrData, words.reloadRd[7:0]};
		end else if (trigFall & ~baudMode & ctrl_q[`T2_BIT_CPRL]) begin
			words.reloadWe = 1'b1;
			words.reloadWr = words.countRd;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// baud clock routing, one-cycle pulses
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rxBaudClock <= 1'b0;
			txBaudClock <= 1'b0;
		end else begin
			rxBaudClock <= ctrl_q[`T2_BIT_RXSEL] ? ovfPulse : timerOneOverflow;
			txBaudClock <= ctrl_q[`T2_BIT_TXSEL] ? ovfPulse : timerOneOverflow;
		end
	end

	// cpu request: level, the flags are never cleared by servicing
	always_ff @(posedge core_clk) begin
		if (srst) begin
			timerIrq <= 1'b0;
		end else begin
			timerIrq <= timerIrqEnable & (ctrlWr[`T2_BIT_OVF] & writeCtrl | ~writeCtrl & ctrl_q[`T2_BIT_OVF]
				| (writeCtrl ? ctrlWr[`T2_BIT_EXT] : ctrl_q[`T2_BIT_EXT]) & ~updownCountEnable
				| ovfPulse & ~baudMode | trigFall & ~updownCountEnable);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sticky event status, write-one clear, enable mask
	logic [2:0] events;
	logic [2:0] irqStatus_d;
	logic [2:0] irqEnable_d;
	assign events = {ovfPulse & baudMode, trigFall, ovfPulse & ~baudMode};

	// a new event beats a same-cycle clear
	always_comb begin
		irqStatus_d = irqStatus_q | events;
		if (regWrite & hit(regAddr, `T2_IRQ_CLEAR_ADDR)) begin
			irqStatus_d = (irqStatus_q & ~regWrData[2:0]) | events;
		end
	end

	always_comb begin
		irqEnable_d = irqEnable_q;
		if (regWrite & hit(regAddr, `T2_IRQ_ENABLE_ADDR)) begin
			irqEnable_d = regWrData[2:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			irqStatus_q <= 3'h0;
		end else begin
			irqStatus_q <= irqStatus_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			irqEnable_q <= 3'h0;
		end else begin
			irqEnable_q <= irqEnable_d;
		end
	end

	// line follows next status and mask, so a clear drops it with no cycle of lag
	always_ff @(posedge core_clk) begin
		if (srst) begin
			irqLine <= 1'b0;
		end else begin
			irqLine <= |(irqStatus_d & irqEnable_d);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk) begin
		if (srst) begin
			regRdData <= 8'h00;
		end else if (regRead) begin
			unique case (regAddr)
				`T2_CTRL_ADDR: regRdData <= ctrl_q;
				`T2_IRQ_STATUS_ADDR: regRdData <= {5'h00, irqStatus_q};
				`T2_IRQ_ENABLE_ADDR: regRdData <= {5'h00, irqEnable_q};
				`T2_COUNT_LO_ADDR: regRdData <= words.countRd[7:0];
				`T2_COUNT_HI_ADDR: regRdData <= words.countRd[15:8];
				`T2_RELOAD_LO_ADDR: regRdData <= words.reloadRd[7:0];
				`T2_RELOAD_HI_ADDR: regRdData <= words.reloadRd[15:8];
				default: regRdData <= 8'h00;
			endcase
		end else begin
			regRdData <= 8'h00;
		end
	end
endmodule : timer_two_ctrl

// >>> sim/timer_two_ctrl_chk.sv
/* port checker of the timer two control block.
   assumes binding onto timer_two_ctrl, one clock, sync reset. */
`timescale 1ns/10ps
`include "timer_two_defs.svh"
module timer_two_ctrl_chk (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] bitMask,
	input wire logic timerOneOverflow,
	input wire logic timerIrqEnable,
	input wire logic [7:0] regRdData,
	input wire logic timerIrq,
	input wire logic rxBaudClock,
	input wire logic txBaudClock,
	input wire logic irqLine
);
	logic [7:0] ctl_q;
	logic [2:0] en_q;
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	// shadow of software bits; flags skipped since hardware sets them
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ctl_q <= 8'h00;
		end else if (regWrite && regAddr == `T2_CTRL_ADDR) begin
			ctl_q <= (ctl_q & ~bitMask) | (regWrData & bitMask);
		end
	end
	always_ff @(posedge core_clk) begin
		if (srst) begin
			en_q <= 3'h0;
		end else if (regWrite && regAddr == `T2_IRQ_ENABLE_ADDR) begin
			en_q <= regWrData[2:0];
		end
	end
	////////////////////////////////////////////////////////////////
	property p_rd_idle; !$past(regRead) |-> regRdData == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	property p_ctl_rd; $past(regRead && regAddr == `T2_CTRL_ADDR) |-> regRdData[5:0] == $past(ctl_q[5:0]); endproperty
	a_ctl_rd: assert property (p_ctl_rd) else $error("control bits read wrong");
	property p_unmapped; $past(regRead && regAddr == `T2_MODE_ADDR) |-> regRdData == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_rx_t1; $past(timerOneOverflow && !ctl_q[5]) |-> rxBaudClock; endproperty
	a_rx_t1: assert property (p_rx_t1) else $error("receive clock missed timer one");
	property p_tx_t1; $past(!timerOneOverflow && !ctl_q[4]) |-> !txBaudClock; endproperty
	a_tx_t1: assert property (p_tx_t1) else $error("stray transmit clock");
	property p_run_off; (ctl_q[5] && !ctl_q[2])[*3] |=> !rxBaudClock; endproperty
	a_run_off: assert property (p_run_off) else $error("overflow while stopped");
	property p_irq_en; !$past(timerIrqEnable) |-> !timerIrq; endproperty
	a_irq_en: assert property (p_irq_en) else $error("timer request while disabled");
	property p_irq_line; en_q == 3'h0 |-> !irqLine; endproperty
	a_irq_line: assert property (p_irq_line) else $error("interrupt line with all masked");
endmodule : timer_two_ctrl_chk
bind timer_two_ctrl timer_two_ctrl_chk chk (.core_clk(core_clk), .srst(srst), .regAddr(regAddr),
	.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .bitMask(bitMask),
	.timerOneOverflow(timerOneOverflow), .timerIrqEnable(timerIrqEnable), .regRdData(regRdData),
	.timerIrq(timerIrq), .rxBaudClock(rxBaudClock), .txBaudClock(txBaudClock), .irqLine(irqLine));

// >>> sim/timer_two_ctrl_test.sv
/* self-checking bench of the timer two control block.
   assumes the design files compiled first; count pin pulsed only in the counter-mode case. */
`timescale 1ns/10ps
module timer_two_ctrl_test;
	logic core_clk = 0, srst = 1, regWrite = 0, regRead = 0, extPin = 1, t1Ovf = 0, updown = 1, irqEn = 0;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, bitMask = 8'h00, regRdData;
	logic timerIrq, rxBaudClock, txBaudClock, irqLine;
	logic cntPin = 1;
	int fails = 0, checkCount = 0, rxN = 0, txN = 0;
	// address, data, mask, expected read-back
	logic [31:0] rows [9] = '{32'hC8FF0404, 32'hC8FF2024, 32'hC8FF1034, 32'hC8000430, 32'hC8FF0838,
		32'hC8FF033B, 32'hC800FF00, 32'hD0FFFF00, 32'hCAFFFF00};
	timer_two_ctrl uut (.core_clk(core_clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .bitMask(bitMask), .externalTriggerPin(extPin),
		.countPin(cntPin), .timerOneOverflow(t1Ovf), .updownCountEnable(updown), .timerIrqEnable(irqEn),
		.regRdData(regRdData), .timerIrq(timerIrq), .rxBaudClock(rxBaudClock), .txBaudClock(txBaudClock),
		.irqLine(irqLine));
	always #25 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		rxN += rxBaudClock;
		txN += txBaudClock;
	end
	////////////////////////////////////////////////////////////////
	task complete_run;
		$display("checks %0d mismatches %0d", checkCount, fails);
		if (fails == 0 && checkCount > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checkCount++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task idle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : idle
	task wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		bitMask <= m;
		regWrite <= 1'b1;
		@(posedge core_clk);
		regWrite <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge core_clk);
		regRead <= 1'b0;
		#1 chk(regRdData, exp);
	endtask : rd
	// overflow every 16 ticks; a 40-cycle window sees two or more pulses
	task baud(input logic [7:0] ctl, input logic [1:0] exp);
		wr(8'hC8, ctl, 8'hFF);
		idle(3);
		rxN = 0;
		txN = 0;
		idle(40);
		chk({6'h00, rxN > 1, txN > 1}, {6'h00, exp});
	endtask : baud
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		rd(8'hC8, 8'h00);
		foreach (rows[i]) begin
			wr(rows[i][31:24], rows[i][23:16], rows[i][15:8]);
			rd(rows[i][31:24], rows[i][7:0]);
		end
		wr(8'hC8, 8'h08, 8'hFF);
		irqEn <= 1'b1;
		extPin <= 1'b0;
		idle(3);
		@(posedge core_clk);
		extPin <= 1'b1;
		rd(8'hC8, 8'h48);
		chk({7'h00, timerIrq}, 8'h00);
		@(posedge core_clk);
		updown <= 1'b0;
		idle(2);
		chk({7'h00, timerIrq}, 8'h01);
		wr(8'hCB, 8'h02, 8'hFF);
		idle(2);
		chk({7'h00, irqLine}, 8'h01);
		wr(8'hCA, 8'h02, 8'hFF);
		idle(2);
		chk({7'h00, irqLine}, 8'h00);
		rd(8'hC8, 8'h48);
		wr(8'hC8, 8'h00, 8'h40);
		rd(8'hC8, 8'h08);
		chk({7'h00, timerIrq}, 8'h00);
		@(posedge core_clk);
		t1Ovf <= 1'b1;
		@(posedge core_clk);
		t1Ovf <= 1'b0;
		wr(8'hCE, 8'hF0, 8'hFF);
		wr(8'hCF, 8'hFF, 8'hFF);
		wr(8'hCC, 8'hF0, 8'hFF);
		wr(8'hCD, 8'hFF, 8'hFF);
		wr(8'hC8, 8'h04, 8'hFF);
		idle(20);
		rd(8'hC8, 8'h84);
		chk({7'h00, timerIrq}, 8'h01);
		idle(20);
		rd(8'hC8, 8'h84);
		baud(8'h24, 2'b10);
		rd(8'hC8, 8'h24);
		baud(8'h14, 2'b01);
		baud(8'h34, 2'b11);
		baud(8'h30, 2'b00);
		// counter mode with capture: three pin edges, then a trigger copies the count
		wr(8'hCC, 8'h00, 8'hFF);
		wr(8'hCD, 8'h00, 8'hFF);
		wr(8'hC8, 8'h0F, 8'hFF);
		repeat (3) begin
			@(posedge core_clk);
			cntPin <= 1'b0;
			@(posedge core_clk);
			cntPin <= 1'b1;
		end
		@(posedge core_clk);
		extPin <= 1'b0;
		@(posedge core_clk);
		extPin <= 1'b1;
		rd(8'hCE, 8'h03);
		rd(8'hCC, 8'h03);
		rd(8'hC8, 8'h4F);
		chk({7'h00, irqLine}, 8'h01);
		rd(8'hC9, 8'h07);
		wr(8'hCA, 8'h07, 8'hFF);
		rd(8'hC9, 8'h00);
		chk({7'h00, irqLine}, 8'h00);
		// reset in mid-run
		@(posedge core_clk);
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		rd(8'hC8, 8'h00);
		chk({7'h00, timerIrq}, 8'h00);
		complete_run;
	end
	initial begin
		#100us;
		fails++;
		complete_run;
	end
endmodule : timer_two_ctrl_test
